// ==== shared/rcr_pkg.sv ====
/*
 * Constants, register map and carrier types for the regulator control register bank.
 * Assumes a plain single-cycle register port with 8-bit addresses and 8-bit data.
 */
// How it works
// - Select pin low: apply primary code
// - Select pin high: apply secondary code
// - Control bit 7 turns channel on
// - Buck two bit 6 selects antiphase
// - Mode bit forces fixed PWM
// - Three-bit turn-on delay code per channel
// - Unmask bit gates fault interrupts
// - Bit 0 reads power-good flag
// - Linear voltage code six bits, top reserved
// - Discharge bit pulls output down when off
// - Low-quiescent bit selects low-power mode
package rcr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_BUCK_TWO_PRI = 8'h30;
    localparam logic [7:0] OFF_BUCK_TWO_SEC = 8'h31;
    localparam logic [7:0] OFF_BUCK_TWO_CTL = 8'h32;
    localparam logic [7:0] OFF_BUCK_THREE_PRI = 8'h40;
    localparam logic [7:0] OFF_BUCK_THREE_SEC = 8'h41;
    localparam logic [7:0] OFF_BUCK_THREE_CTL = 8'h42;
    localparam logic [7:0] OFF_LIN_FOUR_VOLT = 8'h50;
    localparam logic [7:0] OFF_LIN_FOUR_CTL = 8'h51;
    localparam logic [7:0] OFF_LIN_FIVE_VOLT = 8'h54;
    localparam logic [7:0] OFF_LIN_FIVE_CTL = 8'h55;
    localparam logic [7:0] OFF_LIN_SIX_VOLT = 8'h60;
    localparam logic [7:0] OFF_LIN_SIX_CTL = 8'h61;
    localparam logic [7:0] OFF_FAULT_STATUS = 8'h80;
    localparam logic [7:0] OFF_FAULT_MASK = 8'h81;

    // ==========================================================
    // Field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_PHASE = 6;
    localparam int BIT_DISCHARGE = 6;
    localparam int BIT_MODE = 5;
    localparam int BIT_LOW_IQ = 5;
    localparam int BIT_DELAY_LO = 2;
    localparam int BIT_UNMASK = 1;
    localparam int BIT_POWER_GOOD = 0;
    localparam int NUM_CHANNELS = 5;

    // ==========================================================
    // Reset values
    localparam logic [5:0] RST_VOLT_CODE = 6'h00;
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [4:0] RST_FAULT = 5'h00;
    localparam logic [7:0] RST_READ = 8'h00;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic enable;
        logic altBit;
        logic modeBit;
        logic [2:0] delayCode;
        logic unmask;
    } rcr_ctl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rcr_bus_t;

    typedef enum logic [1:0] {
        SEL_PRIMARY,
        SEL_SECONDARY
    } rcr_sel_t;
endpackage

// ==== rtl/rcr_regulator_control_registers.sv ====
/*
 * Register bank for buck two, buck three and linear four to six.
 * Assumes power-good and fault levels synchronous to ref_clk; select pin asynchronous.
 */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module rcr_regulator_control_registers import rcr_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // Analog side
    input wire logic voltageChoicePin,
    input wire logic [4:0] powerGood,
    input wire logic [4:0] faultEvent,
    // Channel controls, channelOn and turnOnDelay index 0 buck two .. 4 linear six
    output logic [5:0] buckTwoCode,
    output logic [5:0] buckThreeCode,
    output logic [5:0] linearFourCode,
    output logic [5:0] linearFiveCode,
    output logic [5:0] linearSixCode,
    output logic [4:0] channelOn,
    output logic buckTwoAntiphase,
    output logic [1:0] buckForcePwm,
    output logic [2:0] linearLowQuiescent,
    output logic [2:0] linearDischarge,
    output logic [14:0] turnOnDelay,
    output logic faultIrq
);
    // ==========================================================
    // Storage
    rcr_bus_t bus;
    logic [5:0] priCode_q [2];
    logic [5:0] secCode_q [2];
    logic [5:0] linCode_q [3];
    rcr_ctl_t ctl_q [NUM_CHANNELS];
    logic [4:0] faultStat_q;
    logic [4:0] faultMask_q;
    logic selMeta_q;
    logic selSync_q;
    logic [4:0] unmaskVec;
    logic [7:0] readData;
    logic [4:0] statW1c;

    assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    function automatic logic [7:0] ctlByte(input rcr_ctl_t c, input logic pg);
        ctlByte = {c.enable, c.altBit, c.modeBit, c.delayCode, c.unmask, pg};
    endfunction

    function automatic rcr_ctl_t ctlFromByte(input logic [7:0] b, input logic keepAlt);
        ctlFromByte.enable = b[BIT_ENABLE];
        ctlFromByte.altBit = keepAlt ? b[BIT_PHASE] : 1'b0;
        ctlFromByte.modeBit = b[BIT_MODE];
        ctlFromByte.delayCode = b[BIT_DELAY_LO +: 3];
        ctlFromByte.unmask = b[BIT_UNMASK];
    endfunction

    // ==========================================================
    // Select pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            selMeta_q <= 1'b0;
            selSync_q <= 1'b0;
        end else begin
            selMeta_q <= voltageChoicePin;
            selSync_q <= selMeta_q;
        end
    end

    // ==========================================================
    // Voltage code registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            priCode_q <= '{RST_VOLT_CODE, RST_VOLT_CODE};
            secCode_q <= '{RST_VOLT_CODE, RST_VOLT_CODE};
            linCode_q <= '{RST_VOLT_CODE, RST_VOLT_CODE, RST_VOLT_CODE};
        end else if (bus.wr) begin
            case (bus.addr)
                OFF_BUCK_TWO_PRI: priCode_q[0] <= bus.wdata[5:0];
                OFF_BUCK_TWO_SEC: secCode_q[0] <= bus.wdata[5:0];
                OFF_BUCK_THREE_PRI: priCode_q[1] <= bus.wdata[5:0];
                OFF_BUCK_THREE_SEC: secCode_q[1] <= bus.wdata[5:0];
                OFF_LIN_FOUR_VOLT: linCode_q[0] <= bus.wdata[5:0];
                OFF_LIN_FIVE_VOLT: linCode_q[1] <= bus.wdata[5:0];
                OFF_LIN_SIX_VOLT: linCode_q[2] <= bus.wdata[5:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                ctl_q[i] <= rcr_ctl_t'(RST_CTL[7:1]);
            end
        end else if (bus.wr) begin
            case (bus.addr)
                OFF_BUCK_TWO_CTL: ctl_q[0] <= ctlFromByte(bus.wdata, 1'b1);
                // Bit 6 reserved on buck three, held at zero
                OFF_BUCK_THREE_CTL: ctl_q[1] <= ctlFromByte(bus.wdata, 1'b0);
                OFF_LIN_FOUR_CTL: ctl_q[2] <= ctlFromByte(bus.wdata, 1'b1);
                OFF_LIN_FIVE_CTL: ctl_q[3] <= ctlFromByte(bus.wdata, 1'b1);
                OFF_LIN_SIX_CTL: ctl_q[4] <= ctlFromByte(bus.wdata, 1'b1);
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Fault interrupt status and mask
    always_comb begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            unmaskVec[i] = ctl_q[i].unmask;
        end
        statW1c = (bus.wr && bus.addr == OFF_FAULT_STATUS) ? bus.wdata[4:0] : 5'h00;
    end

    // Set wins over a same-cycle clear so no unmasked fault is lost
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            faultStat_q <= RST_FAULT;
        end else begin
            faultStat_q <= (faultStat_q & ~statW1c) | (faultEvent & unmaskVec);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            faultMask_q <= RST_FAULT;
        end else if (bus.wr && bus.addr == OFF_FAULT_MASK) begin
            faultMask_q <= bus.wdata[4:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            faultIrq <= 1'b0;
        end else begin
            faultIrq <= |(faultStat_q & faultMask_q & unmaskVec);
        end
    end

    // ==========================================================
    // Read path
    always_comb begin
        readData = RST_READ;
        case (bus.addr)
            OFF_BUCK_TWO_PRI: readData = {2'b00, priCode_q[0]};
            OFF_BUCK_TWO_SEC: readData = {2'b00, secCode_q[0]};
            OFF_BUCK_TWO_CTL: readData = ctlByte(ctl_q[0], powerGood[0]);
            OFF_BUCK_THREE_PRI: readData = {2'b00, priCode_q[1]};
            OFF_BUCK_THREE_SEC: readData = {2'b00, secCode_q[1]};
            OFF_BUCK_THREE_CTL: readData = ctlByte(ctl_q[1], powerGood[1]);
            OFF_LIN_FOUR_VOLT: readData = {2'b00, linCode_q[0]};
            OFF_LIN_FOUR_CTL: readData = ctlByte(ctl_q[2], powerGood[2]);
            OFF_LIN_FIVE_VOLT: readData = {2'b00, linCode_q[1]};
            OFF_LIN_FIVE_CTL: readData = ctlByte(ctl_q[3], powerGood[3]);
            OFF_LIN_SIX_VOLT: readData = {2'b00, linCode_q[2]};
            OFF_LIN_SIX_CTL: readData = ctlByte(ctl_q[4], powerGood[4]);
            OFF_FAULT_STATUS: readData = {3'b000, faultStat_q};
            OFF_FAULT_MASK: readData = {3'b000, faultMask_q};
            default: readData = RST_READ;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdata <= RST_READ;
        end else if (bus.rd) begin
            regRdata <= readData;
        end else begin
            regRdata <= RST_READ;
        end
    end

    // ==========================================================
    // Applied channel settings
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            buckTwoCode <= RST_VOLT_CODE;
            buckThreeCode <= RST_VOLT_CODE;
        end else if (selSync_q) begin
            buckTwoCode <= secCode_q[0];
            buckThreeCode <= secCode_q[1];
        end else begin
            buckTwoCode <= priCode_q[0];
            buckThreeCode <= priCode_q[1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            linearFourCode <= RST_VOLT_CODE;
            linearFiveCode <= RST_VOLT_CODE;
            linearSixCode <= RST_VOLT_CODE;
            channelOn <= 5'h00;
            buckTwoAntiphase <= 1'b0;
            buckForcePwm <= 2'b00;
            linearLowQuiescent <= 3'b000;
            linearDischarge <= 3'b000;
            turnOnDelay <= 15'h0000;
        end else begin
            linearFourCode <= linCode_q[0];
            linearFiveCode <= linCode_q[1];
            linearSixCode <= linCode_q[2];
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                channelOn[i] <= ctl_q[i].enable;
                turnOnDelay[3*i +: 3] <= ctl_q[i].delayCode;
            end
            buckTwoAntiphase <= ctl_q[0].altBit;
            buckForcePwm <= {ctl_q[1].modeBit, ctl_q[0].modeBit};
            for (int j = 0; j < 3; j++) begin
                linearLowQuiescent[j] <= ctl_q[j+2].modeBit;
                // Pull-down only while off, never fighting a live output
                linearDischarge[j] <= ctl_q[j+2].altBit & ~ctl_q[j+2].enable;
            end
        end
    end
endmodule // rcr_regulator_control_registers

// ==== test/rcr_assertions.sv ====
/* Checker for the regulator control register bank.
   Bound to the top module; one clock domain. */
`timescale 1ns/1ps
module rcr_checker import rcr_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    // Pins and controls
    input wire logic voltageChoicePin,
    input wire logic [4:0] powerGood,
    input wire logic [5:0] buckTwoCode,
    input wire logic [4:0] channelOn,
    input wire logic buckTwoAntiphase,
    input wire logic [1:0] buckForcePwm,
    input wire logic [2:0] linearLowQuiescent,
    input wire logic [2:0] linearDischarge,
    input wire logic [14:0] turnOnDelay,
    input wire logic faultIrq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Steps
    sequence wrTo(logic [7:0] a);
        regWr && regAddr == a;
    endsequence
    // Pin must be stable long enough to clear the synchroniser
    sequence pinHeld(logic v);
        (voltageChoicePin == v) [*3];
    endsequence
    // ==========================================================
    // Properties
    pri_code_a: assert property (pinHeld(1'b0) ##0 wrTo(8'h30) |-> ##2
        buckTwoCode == $past(regWdata[5:0], 2)) else $error("primary code");
    sec_code_a: assert property (pinHeld(1'b1) ##0 wrTo(8'h31) |-> ##2
        buckTwoCode == $past(regWdata[5:0], 2)) else $error("secondary code");
    chan_on_a: assert property (wrTo(8'h42) |-> ##2
        channelOn[1] == $past(regWdata[7], 2)) else $error("enable");
    phase_sel_a: assert property (wrTo(8'h32) |-> ##2
        buckTwoAntiphase == $past(regWdata[6], 2)) else $error("phase");
    pwm_mode_a: assert property (wrTo(8'h32) |-> ##2
        buckForcePwm[0] == $past(regWdata[5], 2)) else $error("mode");
    delay_code_a: assert property (wrTo(8'h61) |-> ##2
        turnOnDelay[14:12] == $past(regWdata[4:2], 2)) else $error("delay");
    irq_mask_a: assert property (wrTo(8'h81) ##0 regWdata == 8'h00
        |-> ##2 !faultIrq) else $error("irq not masked");
    good_flag_a: assert property (regRd && regAddr == 8'h32 |=>
        regRdata[0] == $past(powerGood[0])) else $error("power good");
    rsv_read_a: assert property (regRd && regAddr == 8'h50 |=>
        regRdata[7:6] == 2'b00) else $error("reserved bits");
    out_dis_a: assert property (wrTo(8'h51) |-> ##2 linearDischarge[0] ==
        ($past(regWdata[6], 2) && !$past(regWdata[7], 2))) else $error("discharge");
    low_iq_a: assert property (wrTo(8'h55) |-> ##2
        linearLowQuiescent[1] == $past(regWdata[5], 2)) else $error("low iq");
endmodule // rcr_checker

bind rcr_regulator_control_registers rcr_checker u_chk (.ref_clk, .rst, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .voltageChoicePin, .powerGood, .buckTwoCode,
    .channelOn, .buckTwoAntiphase, .buckForcePwm, .linearLowQuiescent, .linearDischarge,
    .turnOnDelay, .faultIrq);

// ==== test/rcr_regulator_control_registers_tb.sv ====
/* Self-checking bench for the regulator control register bank.
   Assumes design and checker compiled before it. */
`timescale 1ns/1ps
module rcr_regulator_control_registers_tb import rcr_pkg::*; ;
    logic ref_clk, rst, regWr, regRd, voltageChoicePin, faultIrq, buckTwoAntiphase;
    logic [7:0] regAddr, regWdata, regRdata, v;
    logic [4:0] powerGood, faultEvent, channelOn;
    logic [5:0] buckTwoCode, buckThreeCode, linearFourCode, linearFiveCode, linearSixCode;
    logic [1:0] buckForcePwm;
    logic [2:0] linearLowQuiescent, linearDischarge;
    logic [14:0] turnOnDelay;
    int num_errors, checks_done, seed;
    bit [7:0] regs [256];
    bit [7:0] adrs [14] = '{8'h30, 8'h31, 8'h32, 8'h40, 8'h41, 8'h42, 8'h50,
        8'h51, 8'h54, 8'h55, 8'h60, 8'h61, 8'h70, 8'h81};
    rcr_regulator_control_registers u_dut (.ref_clk, .rst, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .voltageChoicePin, .powerGood, .faultEvent,
        .buckTwoCode, .buckThreeCode, .linearFourCode, .linearFiveCode, .linearSixCode,
        .channelOn, .buckTwoAntiphase, .buckForcePwm, .linearLowQuiescent,
        .linearDischarge, .turnOnDelay, .faultIrq);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // Model and tasks
    function automatic bit [7:0] ex(input bit [7:0] a);
        bit [7:0] m;
        case (a)
            8'h30, 8'h31, 8'h40, 8'h41, 8'h50, 8'h54, 8'h60: m = 8'h3f;
            8'h32, 8'h51, 8'h55, 8'h61: m = 8'hfe;
            8'h42: m = 8'hbe;
            8'h81: m = 8'h1f;
            default: m = 8'h00;
        endcase
        ex = regs[a] & m;
        case (a)
            8'h32: ex[0] = powerGood[0];
            8'h42: ex[0] = powerGood[1];
            8'h51: ex[0] = powerGood[2];
            8'h55: ex[0] = powerGood[3];
            8'h61: ex[0] = powerGood[4];
            default: ;
        endcase
    endfunction
    function automatic logic [31:0] eo();
        bit [7:0] b2, b3, l4, l5, l6;
        b2 = regs[8'h32];
        b3 = regs[8'h42];
        l4 = regs[8'h51];
        l5 = regs[8'h55];
        l6 = regs[8'h61];
        eo = {3'b000, l6[7], l5[7], l4[7], b3[7], b2[7], b2[6], b3[5], b2[5], l6[5], l5[5],
            l4[5], l6[6] & ~l6[7], l5[6] & ~l5[7], l4[6] & ~l4[7], l6[4:2], l5[4:2],
            l4[4:2], b3[4:2], b2[4:2]};
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input bit [7:0] a, input bit [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        regs[a] = d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task rd(input bit [7:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 q = regRdata;
    endtask
    task settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        {regWr, regRd, regAddr, regWdata, voltageChoicePin, faultEvent} = '0;
        rst = 1'b1;
        seed = 32'h97e2_2ac2;
        powerGood = 5'h00;
        num_errors = 0;
        checks_done = 0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        powerGood <= 5'($random(seed));
        settle(1);
        chk({3'b000, channelOn, buckTwoAntiphase, buckForcePwm, linearLowQuiescent,
            linearDischarge, turnOnDelay}, eo());
        repeat (4) begin
            foreach (adrs[i]) begin
                rd(adrs[i], v);
                chk(v, ex(adrs[i]));
                wr(adrs[i], 8'($random(seed)));
                rd(adrs[i], v);
                chk(v, ex(adrs[i]));
            end
            settle(2);
            chk({3'b000, channelOn, buckTwoAntiphase, buckForcePwm, linearLowQuiescent,
                linearDischarge, turnOnDelay}, eo());
            chk({linearFourCode, linearFiveCode, linearSixCode}, {regs[8'h50][5:0],
                regs[8'h54][5:0], regs[8'h60][5:0]});
        end
        $display("register pass done");
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk) voltageChoicePin <= p[0];
            repeat (4) @(posedge ref_clk);
            wr(8'h30 + 8'(p), 8'($random(seed)));
            wr(8'h40 + 8'(p), 8'($random(seed)));
            settle(3);
            chk({buckTwoCode, buckThreeCode}, {regs[8'h30 + p][5:0],
                regs[8'h40 + p][5:0]});
        end
        $display("select pin test done");
        wr(8'h32, 8'h02);
        wr(8'h42, 8'h00);
        wr(8'h81, 8'h1f);
        @(posedge ref_clk) faultEvent <= 5'h03;
        @(posedge ref_clk) faultEvent <= 5'h00;
        settle(3);
        chk(faultIrq, 1'b1);
        rd(8'h80, v);
        chk(v, 8'h01);
        wr(8'h81, 8'h00);
        settle(3);
        chk(faultIrq, 1'b0);
        wr(8'h80, 8'h01);
        wr(8'h81, 8'h1f);
        rd(8'h80, v);
        chk({v, faultIrq}, 9'h000);
        $display("fault test done");
        stop_test;
    end
    // Hang guard
    initial begin
        #200000;
        num_errors++;
        stop_test;
    end
endmodule // rcr_regulator_control_registers_tb
